// ---- mcgs_pkg.sv ----
// Package: constants, types and decode helpers of the global check status block
package mcgs_pkg;

  // ----------------------------------------------------------------
  // Bus shape and register map
  // ----------------------------------------------------------------
  localparam int MCGS_ADDR_W = 12;
  localparam int MCGS_DATA_W = 64;
  localparam logic [11:0] MCGS_GSTAT_ADDR = 12'h17A;
  localparam logic [11:0] MCGS_IRQ_STAT_ADDR = 12'h17B;
  localparam logic [11:0] MCGS_IRQ_CLR_ADDR = 12'h17C;
  localparam logic [11:0] MCGS_IRQ_EN_ADDR = 12'h17D;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MCGS_RESTART_BIT = 0;
  localparam int MCGS_ERRIP_BIT = 1;
  localparam int MCGS_INPROG_BIT = 2;
  localparam int MCGS_FLAG_W = 3;
  localparam logic MCGS_FLAG_RESET = 1'b0;
  localparam int MCGS_EVT_W = 2;
  localparam int MCGS_EVT_EXC = 0;
  localparam int MCGS_EVT_SHUT = 1;
  localparam logic [1:0] MCGS_IRQ_RESET = 2'h0;
  localparam logic [63:0] MCGS_RDATA_RESET = 64'h0;

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic {MCGS_RUN, MCGS_SHUTDOWN} mcgs_state_t;

  // Address match used by every access decode
  function automatic logic mcgs_hit(input logic [11:0] addr,
                                    input logic [11:0] ref_addr);
    mcgs_hit = (addr == ref_addr);
  endfunction : mcgs_hit

endpackage : mcgs_pkg

// ---- mcgs_irq_if.sv ----
// Interface: link between the status core and its interrupt unit
`timescale 1ns/1ps
`default_nettype none
interface mcgs_irq_if;
  import mcgs_pkg::*;
  logic [MCGS_EVT_W-1:0] event_pulse;
  logic [MCGS_EVT_W-1:0] clear;
  logic [MCGS_EVT_W-1:0] enable_wdata;
  logic enable_we;
  logic [MCGS_EVT_W-1:0] status;
  logic [MCGS_EVT_W-1:0] enable;
  logic irq;

  modport core (output event_pulse, output clear, output enable_wdata,
                output enable_we, input status, input enable, input irq);
  modport unit (input event_pulse, input clear, input enable_wdata,
                input enable_we, output status, output enable, output irq);
endinterface : mcgs_irq_if
`default_nettype wire

// ---- mcgs_irq.sv ----
// Interrupt unit: sticky event status, enable mask, level output
`timescale 1ns/1ps
`default_nettype none
module mcgs_irq
  import mcgs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link to the status core
  mcgs_irq_if.unit lnk
);

  logic [MCGS_EVT_W-1:0] status_reg;
  logic [MCGS_EVT_W-1:0] status_next;
  logic [MCGS_EVT_W-1:0] enable_reg;
  logic [MCGS_EVT_W-1:0] enable_next;

  // Set wins over a clear in the same cycle
  assign status_next = (status_reg & ~lnk.clear) | lnk.event_pulse;
  assign enable_next = lnk.enable_we ? lnk.enable_wdata : enable_reg;

  // Status and enable registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_reg <= MCGS_IRQ_RESET;
      enable_reg <= MCGS_IRQ_RESET;
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
    end
  end

  // Outputs toward the core
  assign lnk.status = status_reg;
  assign lnk.enable = enable_reg;
  assign lnk.irq = |(status_reg & enable_reg);

endmodule : mcgs_irq
`default_nettype wire

// ---- mcgs_top.sv ----
// Global machine-check status register with shutdown and interrupt logic
//
// Overview of operation
// RULE_01: On an accepted check, bit 0 records whether the saved pointer restarts.
// RULE_02: On an accepted check, bit 1 records whether the pointer caused the error.
// RULE_03: Each raised exception sets bit 2; it stays until software clears it.
// RULE_04: A check arriving while bit 2 is set enters shutdown, no new exception.
// RULE_05: Software writes bit 2 to zero after handling a machine check.
// RULE_06: Bits 63 to 3 read zero; writing zero to bit 2 clears only it.
`timescale 1ns/1ps
`default_nettype none
module mcgs_top
  import mcgs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [MCGS_ADDR_W-1:0] reg_addr,
  input wire logic [MCGS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [MCGS_DATA_W-1:0] reg_rdata,
  // Check reports from the core
  input wire logic mc_event,
  input wire logic mc_restart_ok,
  input wire logic mc_ip_assoc,
  // Results
  output logic mc_exception,
  output logic shutdown,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mcgs_state_t state_reg;
  mcgs_state_t state_next;
  logic restart_reg;
  logic restart_next;
  logic errip_reg;
  logic errip_next;
  logic inprog_reg;
  logic inprog_next;
  logic exc_reg;
  logic [MCGS_DATA_W-1:0] rdata_reg;
  logic [MCGS_DATA_W-1:0] rdata_next;

  mcgs_irq_if irq_lnk ();

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire running = (state_reg == MCGS_RUN);
  wire accept = mc_event && running && !inprog_reg;
  wire second = mc_event && running && inprog_reg; // see RULE_04
  wire gstat_wr = reg_wr && mcgs_hit(reg_addr, MCGS_GSTAT_ADDR);
  wire sw_clr = gstat_wr && !reg_wdata[MCGS_INPROG_BIT]; // see RULE_06
  wire clr_wr = reg_wr && mcgs_hit(reg_addr, MCGS_IRQ_CLR_ADDR);
  wire en_wr = reg_wr && mcgs_hit(reg_addr, MCGS_IRQ_EN_ADDR);
  wire [MCGS_FLAG_W-1:0] gstat = {inprog_reg, errip_reg, restart_reg};

  // Flag updates; a new check beats a software clear
  assign restart_next = accept ? mc_restart_ok : restart_reg; // see RULE_01
  assign errip_next = accept ? mc_ip_assoc : errip_reg; // see RULE_02
  assign inprog_next = accept ? 1'b1 :
                       (sw_clr ? 1'b0 : inprog_reg); // see RULE_03

  // Run or shutdown; shutdown holds until reset and blocks later checks
  always_comb begin
    case (state_reg)
      MCGS_RUN: begin
        state_next = second ? MCGS_SHUTDOWN : MCGS_RUN; // see RULE_04
      end
      MCGS_SHUTDOWN: begin
        state_next = MCGS_SHUTDOWN; // see RULE_04
      end
      default: begin
        state_next = MCGS_RUN;
      end
    endcase
  end

  // Read mux, reserved bits zero, unmapped reads zero
  wire [MCGS_DATA_W-1:0] gstat_rd = {{(MCGS_DATA_W-MCGS_FLAG_W){1'b0}},
                                     gstat}; // see RULE_06
  wire [MCGS_DATA_W-1:0] irqs_rd = {{(MCGS_DATA_W-MCGS_EVT_W){1'b0}},
                                    irq_lnk.status};
  wire [MCGS_DATA_W-1:0] irqe_rd = {{(MCGS_DATA_W-MCGS_EVT_W){1'b0}},
                                    irq_lnk.enable};
  assign rdata_next =
    !reg_rd ? MCGS_RDATA_RESET :
    mcgs_hit(reg_addr, MCGS_GSTAT_ADDR) ? gstat_rd :
    mcgs_hit(reg_addr, MCGS_IRQ_STAT_ADDR) ? irqs_rd :
    mcgs_hit(reg_addr, MCGS_IRQ_EN_ADDR) ? irqe_rd : MCGS_RDATA_RESET;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= MCGS_RUN;
      restart_reg <= MCGS_FLAG_RESET;
      errip_reg <= MCGS_FLAG_RESET;
      inprog_reg <= MCGS_FLAG_RESET;
      exc_reg <= 1'b0;
      rdata_reg <= MCGS_RDATA_RESET;
    end else begin
      state_reg <= state_next;
      restart_reg <= restart_next;
      errip_reg <= errip_next;
      inprog_reg <= inprog_next;
      exc_reg <= accept; // see RULE_03
      rdata_reg <= rdata_next;
    end
  end

  // Interrupt unit hookup
  assign irq_lnk.event_pulse = {second, accept};
  assign irq_lnk.clear = clr_wr ? reg_wdata[MCGS_EVT_W-1:0] : MCGS_IRQ_RESET;
  assign irq_lnk.enable_we = en_wr;
  assign irq_lnk.enable_wdata = reg_wdata[MCGS_EVT_W-1:0];

  mcgs_irq u_irq (
    .ref_clk(ref_clk),
    .rst(rst),
    .lnk(irq_lnk.unit)
  );

  // Outputs
  assign reg_rdata = rdata_reg;
  assign mc_exception = exc_reg;
  assign shutdown = (state_reg == MCGS_SHUTDOWN);
  assign irq = irq_lnk.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Restart flag follows the report of the accepted check
  AST_RESTART_CAPTURE: assert property ( // see RULE_01
    accept |=> restart_reg == $past(mc_restart_ok) && mc_exception)
    else $error("restart flag not captured");

  // Error pointer flag changes only on an accepted check
  AST_ERRIP_HOLD: assert property ( // see RULE_02
    !$past(accept) |-> $stable(errip_reg))
    else $error("error pointer flag moved without a check");

  // In-progress sets with the exception and holds until cleared
  AST_INPROG_SET: assert property ( // see RULE_03
    accept |=> inprog_reg ##0 mc_exception ##1 !mc_exception)
    else $error("in-progress flag or exception pulse wrong");

  AST_INPROG_KEEP: assert property ( // see RULE_03
    inprog_reg && !sw_clr |=> inprog_reg)
    else $error("in-progress flag dropped on its own");

  // Second check goes to shutdown and raises no exception
  AST_SHUTDOWN: assert property ( // see RULE_04
    second |=> shutdown && !mc_exception ##1 shutdown && !mc_exception)
    else $error("second check did not shut down");

  // Status read shows flags in the low bits, zeros above
  AST_READ_FORM: assert property ( // see RULE_06
    reg_rd && mcgs_hit(reg_addr, MCGS_GSTAT_ADDR) |=>
    reg_rdata == {61'h0, $past(gstat)})
    else $error("status read value wrong");

  // Clearing write drops only the in-progress flag
  AST_CLEAR_ONLY: assert property ( // see RULE_06
    sw_clr && !mc_event |=> !inprog_reg && $stable(restart_reg)
    && $stable(errip_reg))
    else $error("clearing write disturbed other flags");

  // Restart flag changes only on an accepted check
  AST_RESTART_HOLD: assert property ( // see RULE_01
    !$past(accept) |-> $stable(restart_reg))
    else $error("restart flag moved without a check");

  // Error pointer flag follows the report of the accepted check
  AST_ERRIP_CAPTURE: assert property ( // see RULE_02
    accept |=> errip_reg == $past(mc_ip_assoc))
    else $error("error pointer flag not captured");

  // Exception pulse only ever follows an accepted check
  AST_EXC_SOURCE: assert property ( // see RULE_03
    mc_exception |-> $past(accept))
    else $error("exception without an accepted check");

  // Shutdown never leaves before reset
  AST_SHUT_STICKY: assert property ( // see RULE_04
    shutdown |=> shutdown)
    else $error("shutdown state left");

  // Checks during shutdown raise nothing and move no capture flag
  AST_SHUT_SILENT: assert property ( // see RULE_04
    shutdown |=> !mc_exception && $stable(restart_reg)
    && $stable(errip_reg))
    else $error("check acted on during shutdown");

  // Shutdown entry is recorded in the interrupt status
  AST_SHUT_EVENT: assert property ( // see RULE_04
    second |=> irq_lnk.status[MCGS_EVT_SHUT])
    else $error("shutdown event not recorded");

  // Writing one to the in-progress flag changes nothing
  AST_WRITE_ONE: assert property ( // see RULE_06
    gstat_wr && reg_wdata[MCGS_INPROG_BIT] && !mc_event |=> $stable(gstat))
    else $error("write of one disturbed the flags");

  // Upper read bits are always zero
  AST_RESERVED_ZERO: assert property ( // see RULE_06
    reg_rdata[MCGS_DATA_W-1:MCGS_FLAG_W] == '0)
    else $error("reserved read bits not zero");

  COV_ACCEPT: cover property (accept ##1 mc_exception);
  COV_SHUTDOWN: cover property (accept ##[1:20] second);
  COV_CLEAR_AGAIN: cover property (sw_clr && inprog_reg ##[1:8] accept);
  COV_IRQ: cover property (irq);
  COV_COLLIDE: cover property (accept && sw_clr);

endmodule : mcgs_top
`default_nettype wire

// ---- tb_machine_check_global_status.sv ----
// Testbench: self-checking bench of the global check status block
`timescale 1ns/1ps
`default_nettype none
module tb_machine_check_global_status;
  import mcgs_pkg::*;
  // ----------------------------------------------------------------
  // Signals, clock, counters
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [63:0] reg_wdata = 64'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [63:0] reg_rdata;
  logic mc_event = 1'b0;
  logic mc_restart_ok = 1'b0;
  logic mc_ip_assoc = 1'b0;
  logic mc_exception, shutdown, irq;
  int error_cnt = 0;
  int check_count = 0;
  always #10 ref_clk = ~ref_clk;
  mcgs_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mc_event(mc_event),
    .mc_restart_ok(mc_restart_ok), .mc_ip_assoc(mc_ip_assoc),
    .mc_exception(mc_exception), .shutdown(shutdown), .irq(irq));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(logic [11:0] a, logic [63:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // Read data looked at in the one cycle after the strobe
  task automatic rd(logic [11:0] a, logic [63:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, exp);
    @(posedge ref_clk);
    #1 chk("rdata idle", reg_rdata, 64'h0);
  endtask : rd
  // Single check report, exception pulse expected or not
  task automatic evt(logic r, logic a, logic exc);
    @(posedge ref_clk);
    mc_event <= 1'b1;
    mc_restart_ok <= r;
    mc_ip_assoc <= a;
    @(posedge ref_clk);
    mc_event <= 1'b0;
    #1 chk("exception", {63'h0, mc_exception}, {63'h0, exc});
  endtask : evt
  task automatic final_report;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(MCGS_GSTAT_ADDR, 64'h0);
    rd(MCGS_IRQ_STAT_ADDR, 64'h0);
    rd(MCGS_IRQ_EN_ADDR, 64'h0);
    rd(MCGS_IRQ_CLR_ADDR, 64'h0);
    rd(12'h3FF, 64'h0);
    chk("irq", {63'h0, irq}, 64'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_first;
    evt(1'b1, 1'b0, 1'b1);
    @(posedge ref_clk);
    #1 chk("exc end", {63'h0, mc_exception}, 64'h0);
    rd(MCGS_GSTAT_ADDR, 64'h5);
    rd(MCGS_IRQ_STAT_ADDR, 64'h1);
    chk("irq masked", {63'h0, irq}, 64'h0);
    wr(MCGS_GSTAT_ADDR, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(MCGS_GSTAT_ADDR, 64'h5);
    wr(MCGS_GSTAT_ADDR, 64'h0);
    rd(MCGS_GSTAT_ADDR, 64'h1);
    $display("test first check done");
  endtask : t_first
  task automatic t_second;
    evt(1'b0, 1'b1, 1'b1);
    rd(MCGS_GSTAT_ADDR, 64'h6);
    wr(MCGS_IRQ_EN_ADDR, 64'h3);
    chk("irq on", {63'h0, irq}, 64'h1);
    rd(MCGS_IRQ_EN_ADDR, 64'h3);
    wr(MCGS_IRQ_CLR_ADDR, 64'h1);
    chk("irq off", {63'h0, irq}, 64'h0);
    rd(MCGS_IRQ_STAT_ADDR, 64'h0);
    wr(MCGS_GSTAT_ADDR, 64'h0);
    rd(MCGS_GSTAT_ADDR, 64'h2);
    $display("test second check done");
  endtask : t_second
  // Check and clearing write in one cycle: the check wins
  task automatic t_collide;
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= MCGS_GSTAT_ADDR;
    reg_wdata <= 64'h0;
    mc_event <= 1'b1;
    mc_restart_ok <= 1'b0;
    mc_ip_assoc <= 1'b0;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    mc_event <= 1'b0;
    #1 chk("exc collide", {63'h0, mc_exception}, 64'h1);
    rd(MCGS_GSTAT_ADDR, 64'h4);
    wr(MCGS_GSTAT_ADDR, 64'h0);
    rd(MCGS_GSTAT_ADDR, 64'h0);
    $display("test collision done");
  endtask : t_collide
  task automatic t_shut;
    @(posedge ref_clk);
    mc_event <= 1'b1;
    mc_restart_ok <= 1'b1;
    mc_ip_assoc <= 1'b1;
    @(posedge ref_clk);
    #1 chk("exc one", {63'h0, mc_exception}, 64'h1);
    @(posedge ref_clk);
    mc_event <= 1'b0;
    #1 chk("shutdown", {63'h0, shutdown}, 64'h1);
    chk("no exc", {63'h0, mc_exception}, 64'h0);
    chk("irq shut", {63'h0, irq}, 64'h1);
    rd(MCGS_IRQ_STAT_ADDR, 64'h3);
    wr(MCGS_IRQ_CLR_ADDR, 64'h3);
    evt(1'b0, 1'b0, 1'b0);
    chk("irq held", {63'h0, irq}, 64'h0);
    rd(MCGS_GSTAT_ADDR, 64'h7);
    chk("shut held", {63'h0, shutdown}, 64'h1);
    $display("test shutdown done");
  endtask : t_shut
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_first();
    t_second();
    t_collide();
    t_shut();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
endmodule : tb_machine_check_global_status
`default_nettype wire
